// *** hdl/flow_action_pkg.sv ***
/*
 * shared constants for the flow action configuration block and its datapath end.
 * assumes one 100 MHz clock (mclk) and an asynchronous active-low reset (rstn).
 */
package flow_action_pkg;
	localparam int FLOW_COUNT    = 8;
	localparam int CHANNEL_COUNT = 2;
	localparam int STAGE_COUNT   = 2;
	localparam int POS_W         = 3;
	localparam int BYTES_W       = 4;
	localparam int PTR_W         = 8;
	localparam int GROUP_W       = 2;
	localparam int SIGSRC_W      = 2;
	localparam int PATTERN_W     = 64;
	localparam int HEADER_W      = 128;
	// first header byte sits in the top bits of the header window
	localparam int BYTE_SHIFT    = 3;
	// least spacing between protocol start and second comparator start
	localparam int SPLIT_BITS    = 64;
	localparam logic [PTR_W-1:0] MIN_SPLIT_BYTES = 8'(SPLIT_BITS / 8);
	localparam logic CHKSUM_FROM_COMP1 = 1'b0;
	localparam logic CHKSUM_FROM_COMP2 = 1'b1;
	localparam logic [SIGSRC_W-1:0] SIG_ETH_BLOCK1 = 2'h0;
	localparam logic [SIGSRC_W-1:0] SIG_ETH_BLOCK2 = 2'h1;
	localparam logic [SIGSRC_W-1:0] SIG_IP_BLOCK1  = 2'h2;
	localparam logic [SIGSRC_W-1:0] SIG_IP_BLOCK2  = 2'h3;
	localparam int GROUP_A_BIT = 0;
	localparam int GROUP_B_BIT = 1;
	localparam logic RST_ENABLE = 1'b0;
	localparam logic [PTR_W-1:0] RST_PTR = 8'h00;
endpackage : flow_action_pkg

// *** hdl/flow_link_if.sv ***
/*
 * link between the frame datapath end and the flow action configuration end.
 * assumes both ends run on mclk; no clocking here.
 */
`timescale 1ns/100ps
`default_nettype none
interface flow_link_if #(
	parameter int FLOWS    = flow_action_pkg::FLOW_COUNT,
	parameter int CHANNELS = flow_action_pkg::CHANNEL_COUNT
);
	import flow_action_pkg::*;
	localparam int FW = (FLOWS > 1) ? $clog2(FLOWS) : 1;
	localparam int CW = (CHANNELS > 1) ? $clog2(CHANNELS) : 1;
	logic                  sop;
	logic                  eop;
	logic [CW-1:0]         channel;
	logic                  hdr_valid;
	logic [HEADER_W-1:0]   hdr;
	logic                  eth_found;
	logic [GROUP_W-1:0]    group_in;
	logic [PTR_W-1:0]      proto_start;
	logic                  res_valid;
	logic                  res_match;
	logic [FW-1:0]         res_flow;
	logic [PTR_W-1:0]      status_offset;
	logic                  status_update;
	logic [BYTES_W-1:0]    rewrite_bytes;
	logic [PTR_W-1:0]      rewrite_pos;
	logic [PTR_W-1:0]      cf_loc;
	logic [GROUP_W-1:0]    group_out;
	logic                  chksum_sel;
	logic [SIGSRC_W-1:0]   sig_src;
	logic                  stamp_all;
	modport dev (
		input  sop, eop, channel, hdr_valid, hdr, eth_found, group_in, proto_start,
		output res_valid, res_match, res_flow, status_offset, status_update,
		output rewrite_bytes, rewrite_pos, cf_loc, group_out, chksum_sel, sig_src, stamp_all
	);
	modport dp (
		output sop, eop, channel, hdr_valid, hdr, eth_found, group_in, proto_start,
		input  res_valid, res_match, res_flow, status_offset, status_update,
		input  rewrite_bytes, rewrite_pos, cf_loc, group_out, chksum_sel, sig_src, stamp_all
	);
endinterface : flow_link_if
`default_nettype wire

// *** hdl/frame_datapath_end.sv ***
/*
 * datapath end: registers frame and header events onto the link and
 * captures the per-frame action answer for the rewriter side.
 * assumes user inputs are synchronous to mclk.
 */
`timescale 1ns/100ps
`default_nettype none
module frame_datapath_end #(
	parameter int FLOWS    = flow_action_pkg::FLOW_COUNT,
	parameter int CHANNELS = flow_action_pkg::CHANNEL_COUNT
) (
	input  wire logic                                   mclk,
	input  wire logic                                   rstn,
	flow_link_if.dp                                     lnk,
	input  wire logic                                   frame_sop,
	input  wire logic                                   frame_eop,
	input  wire logic [$clog2(CHANNELS)-1:0]            frame_channel,
	input  wire logic                                   header_valid,
	input  wire logic [flow_action_pkg::HEADER_W-1:0]   header_word,
	input  wire logic                                   eth_header_found,
	input  wire logic [flow_action_pkg::GROUP_W-1:0]    prior_group,
	input  wire logic [flow_action_pkg::PTR_W-1:0]      protocol_start,
	input  wire logic [flow_action_pkg::PTR_W-1:0]      split_start_req,
	output logic                                        action_valid,
	output logic                                        action_match,
	output logic [$clog2(FLOWS)-1:0]                    action_flow,
	output logic [flow_action_pkg::PTR_W-1:0]           status_offset,
	output logic                                        status_update,
	output logic [flow_action_pkg::BYTES_W-1:0]         rewrite_bytes,
	output logic [flow_action_pkg::PTR_W-1:0]           rewrite_pos,
	output logic [flow_action_pkg::PTR_W-1:0]           cf_loc,
	output logic [flow_action_pkg::GROUP_W-1:0]         group_out,
	output logic                                        chksum_sel,
	output logic [flow_action_pkg::SIGSRC_W-1:0]        sig_src,
	output logic                                        stamp_all,
	output logic [flow_action_pkg::PTR_W-1:0]           second_comparator_start
);
	import flow_action_pkg::*;

	logic [PTR_W-1:0] split_floor;

	assign split_floor = 8'(protocol_start + MIN_SPLIT_BYTES);

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			lnk.sop         <= 1'b0;
			lnk.eop         <= 1'b0;
			lnk.channel     <= '0;
			lnk.hdr_valid   <= 1'b0;
			lnk.hdr         <= '0;
			lnk.eth_found   <= 1'b0;
			lnk.group_in    <= '0;
			lnk.proto_start <= RST_PTR;
		end else begin
			lnk.sop       <= frame_sop;
			lnk.eop       <= frame_eop;
			lnk.hdr_valid <= header_valid;
			if (frame_sop) begin
				lnk.channel <= frame_channel;
			end
			if (header_valid) begin
				lnk.hdr         <= header_word;
				lnk.eth_found   <= eth_header_found;
				lnk.group_in    <= prior_group;
				lnk.proto_start <= protocol_start;
			end
		end
	end

	// second comparator never starts inside the first protocol word
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			second_comparator_start <= RST_PTR;
		end else if (header_valid) begin
			second_comparator_start <= (split_start_req < split_floor) ? split_floor
				: split_start_req;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			action_valid  <= 1'b0;
			action_match  <= 1'b0;
			action_flow   <= '0;
			status_offset <= RST_PTR;
			status_update <= 1'b0;
			rewrite_bytes <= '0;
			rewrite_pos   <= RST_PTR;
			cf_loc        <= RST_PTR;
			group_out     <= '0;
			chksum_sel    <= CHKSUM_FROM_COMP1;
			sig_src       <= SIG_ETH_BLOCK1;
			stamp_all     <= 1'b0;
		end else begin
			action_valid <= lnk.res_valid;
			stamp_all    <= lnk.stamp_all;
			if (lnk.res_valid) begin
				action_match  <= lnk.res_match;
				action_flow   <= lnk.res_flow;
				status_offset <= lnk.status_offset;
				status_update <= lnk.status_update;
				rewrite_bytes <= lnk.rewrite_bytes;
				rewrite_pos   <= lnk.rewrite_pos;
				cf_loc        <= lnk.cf_loc;
				group_out     <= lnk.group_out;
				chksum_sel    <= lnk.chksum_sel;
				sig_src       <= lnk.sig_src;
			end
		end
	end
endmodule : frame_datapath_end
`default_nettype wire

// *** hdl/ptp_flow_action_reconfig.sv ***
/*
 * flow action configuration end: holds per-flow and common controls,
 * applies enables cleanly between frames and answers each header with
 * the winning flow's rewrite actions.
 * assumes config inputs come from software-held flops on mclk.
 */
// What this block does
// - status bit position gives rewriter packet offset
// - status update flag forwarded to rewriter
// - per-flow rewrite byte count forwarded
// - per-flow timestamp pointer from delimiter forwarded
// - per-flow correction write location forwarded
// - flow applies only on masked-in channels
// - cleared flow enable makes flow inactive
// - common checksum source selects comparator one/two
// - common two-bit signature address source
// - flow needs group shared with prior stages
// - second comparator starts at least one word later
// - disabled engine config freely rewritable
// - flow config changes only while disabled
// - comparators disableable; no ethernet, no match
// - first ethernet comparator off stamps everything
// - enables change only between frames
// - strict mode: any stage off kills flow
// - common stage settings change with engine off
// - pattern comparator uses configurable field offset
// - 64-bit pattern under shared mask
`timescale 1ns/100ps
`default_nettype none
module ptp_flow_action_reconfig #(
	parameter int FLOWS    = flow_action_pkg::FLOW_COUNT,
	parameter int CHANNELS = flow_action_pkg::CHANNEL_COUNT,
	parameter int STAGES   = flow_action_pkg::STAGE_COUNT
) (
	input  wire logic                                             mclk,
	input  wire logic                                             rstn,
	flow_link_if.dev                                              lnk,
	input  wire logic                                             engine_enable,
	input  wire logic                                             strict_flow_match,
	input  wire logic                                             first_ethernet_comparator,
	input  wire logic                                             pattern_comparator_enable,
	input  wire logic [STAGES-1:0][FLOWS-1:0]                     flow_valid,
	input  wire logic [FLOWS-1:0][flow_action_pkg::POS_W-1:0]     status_bit_byte_position,
	input  wire logic [FLOWS-1:0]                                 status_bit_update_enable,
	input  wire logic [FLOWS-1:0][flow_action_pkg::BYTES_W-1:0]   rewrite_byte_count,
	input  wire logic [FLOWS-1:0][flow_action_pkg::PTR_W-1:0]     rewrite_position,
	input  wire logic [FLOWS-1:0][flow_action_pkg::PTR_W-1:0]     correction_write_location,
	input  wire logic [FLOWS-1:0][CHANNELS-1:0]                   flow_channel_select,
	input  wire logic [FLOWS-1:0][flow_action_pkg::GROUP_W-1:0]   next_protocol_group_gate,
	input  wire logic [FLOWS-1:0][flow_action_pkg::PATTERN_W-1:0] flow_pattern,
	input  wire logic [flow_action_pkg::PATTERN_W-1:0]            flow_pattern_mask,
	input  wire logic [flow_action_pkg::POS_W-1:0]                field_offset,
	input  wire logic                                             checksum_source_select,
	input  wire logic [flow_action_pkg::SIGSRC_W-1:0]             signature_address_source,
	output logic                                                  engine_active,
	output logic [FLOWS-1:0]                                      flow_active
);
	import flow_action_pkg::*;
	localparam int FW = (FLOWS > 1) ? $clog2(FLOWS) : 1;

	function automatic logic field_hit(input logic [HEADER_W-1:0]  hdr,
	                                   input logic [PATTERN_W-1:0] pat,
	                                   input logic [PATTERN_W-1:0] msk,
	                                   input logic [POS_W-1:0]     off);
		logic [HEADER_W-1:0] sh;
		sh = hdr << {off, 3'b000};
		return ((sh[HEADER_W-1 -: PATTERN_W] ^ pat) & msk) == '0;
	endfunction : field_hit

	logic                 in_frame;
	logic                 upd_window;
	logic                 act_eth;
	logic                 act_pat;
	logic [FLOWS-1:0]     req_en;
	logic [FLOWS-1:0]     hit;
	logic                 any_hit;
	logic [FW-1:0]        win;

	logic [FLOWS-1:0][POS_W-1:0]     sh_pos;
	logic [FLOWS-1:0]                sh_upd;
	logic [FLOWS-1:0][BYTES_W-1:0]   sh_bytes;
	logic [FLOWS-1:0][PTR_W-1:0]     sh_rpos;
	logic [FLOWS-1:0][PTR_W-1:0]     sh_cf;
	logic [FLOWS-1:0][CHANNELS-1:0]  sh_chan;
	logic [FLOWS-1:0][GROUP_W-1:0]   sh_gate;
	logic [FLOWS-1:0][PATTERN_W-1:0] sh_pat;
	logic [PATTERN_W-1:0]            c_mask;
	logic [POS_W-1:0]                c_off;
	logic                            c_chk;
	logic [SIGSRC_W-1:0]             c_sig;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			in_frame <= 1'b0;
		end else if (lnk.sop) begin
			in_frame <= 1'b1;
		end else if (lnk.eop) begin
			in_frame <= 1'b0;
		end
	end

	// only in the gap or on the closing beat of a frame
	assign upd_window = (!in_frame && !lnk.sop) || lnk.eop;

	// strict: every stage must keep the flow on
	always_comb begin
		for (int f = 0; f < FLOWS; f++) begin
			req_en[f] = strict_flow_match;
			for (int s = 0; s < STAGES; s++) begin
				if (strict_flow_match) begin
					req_en[f] = req_en[f] & flow_valid[s][f];
				end else begin
					req_en[f] = req_en[f] | flow_valid[s][f];
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			engine_active <= RST_ENABLE;
			flow_active   <= '0;
			act_eth       <= 1'b1;
			act_pat       <= 1'b1;
		end else if (upd_window) begin
			engine_active <= engine_enable;
			flow_active   <= req_en;
			act_eth       <= first_ethernet_comparator;
			act_pat       <= pattern_comparator_enable;
		end
	end

	// per-flow settings follow software only while that flow or the engine is off
	for (genvar f = 0; f < FLOWS; f++) begin : g_shadow
		always_ff @(posedge mclk or negedge rstn) begin
			if (!rstn) begin
				sh_pos[f]   <= '0;
				sh_upd[f]   <= 1'b0;
				sh_bytes[f] <= '0;
				sh_rpos[f]  <= RST_PTR;
				sh_cf[f]    <= RST_PTR;
				sh_chan[f]  <= '0;
				sh_gate[f]  <= '0;
				sh_pat[f]   <= '0;
			end else if (!flow_active[f] || !engine_active) begin
				sh_pos[f]   <= status_bit_byte_position[f];
				sh_upd[f]   <= status_bit_update_enable[f];
				sh_bytes[f] <= rewrite_byte_count[f];
				sh_rpos[f]  <= rewrite_position[f];
				sh_cf[f]    <= correction_write_location[f];
				sh_chan[f]  <= flow_channel_select[f];
				sh_gate[f]  <= next_protocol_group_gate[f];
				sh_pat[f]   <= flow_pattern[f];
			end
		end
	end

	// settings shared by all flows follow software only with engine off
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			c_mask <= '0;
			c_off  <= '0;
			c_chk  <= CHKSUM_FROM_COMP1;
			c_sig  <= SIG_ETH_BLOCK1;
		end else if (!engine_active) begin
			c_mask <= flow_pattern_mask;
			c_off  <= field_offset;
			c_chk  <= checksum_source_select;
			c_sig  <= signature_address_source;
		end
	end

	always_comb begin
		for (int f = 0; f < FLOWS; f++) begin
			hit[f] = engine_active && flow_active[f]
				&& sh_chan[f][lnk.channel]
				&& ((sh_gate[f] & lnk.group_in) != '0)
				&& (!act_eth || lnk.eth_found)
				&& (!act_pat || field_hit(lnk.hdr, sh_pat[f], c_mask, c_off));
		end
	end

	// lowest numbered matching flow wins
	always_comb begin
		win = '0;
		for (int f = FLOWS - 1; f >= 0; f--) begin
			if (hit[f]) begin
				win = FW'(f);
			end
		end
	end

	assign any_hit = |hit;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			lnk.res_valid <= 1'b0;
			lnk.stamp_all <= 1'b0;
		end else begin
			lnk.res_valid <= lnk.hdr_valid;
			lnk.stamp_all <= engine_active && !act_eth;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			lnk.res_match     <= 1'b0;
			lnk.res_flow      <= '0;
			lnk.status_offset <= RST_PTR;
			lnk.status_update <= 1'b0;
			lnk.rewrite_bytes <= '0;
			lnk.rewrite_pos   <= RST_PTR;
			lnk.cf_loc        <= RST_PTR;
			lnk.group_out     <= '0;
			lnk.chksum_sel    <= CHKSUM_FROM_COMP1;
			lnk.sig_src       <= SIG_ETH_BLOCK1;
		end else if (lnk.hdr_valid) begin
			lnk.res_match  <= any_hit;
			lnk.res_flow   <= win;
			lnk.chksum_sel <= c_chk;
			lnk.sig_src    <= c_sig;
			if (any_hit) begin
				lnk.status_offset <= 8'(lnk.proto_start + {5'h00, sh_pos[win]});
				lnk.status_update <= sh_upd[win];
				lnk.rewrite_bytes <= sh_bytes[win];
				lnk.rewrite_pos   <= sh_rpos[win];
				lnk.cf_loc        <= sh_cf[win];
				lnk.group_out     <= sh_gate[win] & lnk.group_in;
			end else begin
				lnk.status_offset <= RST_PTR;
				lnk.status_update <= 1'b0;
				lnk.rewrite_bytes <= '0;
				lnk.rewrite_pos   <= RST_PTR;
				lnk.cf_loc        <= RST_PTR;
				lnk.group_out     <= '0;
			end
		end
	end
endmodule : ptp_flow_action_reconfig
`default_nettype wire

// *** tb/flow_link_sva.sv ***
/*
 * checker on the link between the datapath end and the configuration end.
 * assumes all link signals sampled on mclk, rstn asynchronous active low.
 */
`timescale 1ns/100ps
`default_nettype none
module flow_link_checker (
	input wire logic                                 mclk,
	input wire logic                                 rstn,
	input wire logic                                 sop,
	input wire logic                                 eop,
	input wire logic                                 hdr_valid,
	input wire logic                                 eth_found,
	input wire logic [flow_action_pkg::GROUP_W-1:0]  group_in,
	input wire logic [flow_action_pkg::PTR_W-1:0]    proto_start,
	input wire logic                                 res_valid,
	input wire logic                                 res_match,
	input wire logic [flow_action_pkg::PTR_W-1:0]    status_offset,
	input wire logic                                 status_update,
	input wire logic [flow_action_pkg::BYTES_W-1:0]  rewrite_bytes,
	input wire logic [flow_action_pkg::PTR_W-1:0]    rewrite_pos,
	input wire logic [flow_action_pkg::PTR_W-1:0]    cf_loc,
	input wire logic [flow_action_pkg::GROUP_W-1:0]  group_out,
	input wire logic                                 stamp_all
);
	import flow_action_pkg::*;
	logic in_frame;
	wire logic win;
	// frame tracker, set by start and cleared by end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			in_frame <= 1'b0;
		else if (sop)
			in_frame <= 1'b1;
		else if (eop)
			in_frame <= 1'b0;
	end
	assign win = (!in_frame && !sop) || eop;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	property p_answer; hdr_valid |=> res_valid; endproperty
	a_answer: assert property (p_answer) else $error("no answer after header");
	property p_only_answer; res_valid |-> $past(hdr_valid); endproperty
	a_only_answer: assert property (p_only_answer) else $error("answer without header");
	property p_group_subset; res_valid |-> (group_out & ~$past(group_in)) == '0; endproperty
	a_group_subset: assert property (p_group_subset) else $error("group not from prior");
	property p_hit_group; res_valid && res_match |-> group_out != '0; endproperty
	a_hit_group: assert property (p_hit_group) else $error("hit with empty group");
	property p_miss_quiet;
		res_valid && !res_match |-> !status_update && rewrite_bytes == '0 &&
			rewrite_pos == '0 && cf_loc == '0;
	endproperty
	a_miss_quiet: assert property (p_miss_quiet) else $error("miss carries actions");
	property p_eth_needed; res_valid && res_match && !$past(eth_found) |-> stamp_all; endproperty
	a_eth_needed: assert property (p_eth_needed) else $error("hit without header");
	property p_status_pos;
		res_valid && res_match |-> 8'(status_offset - $past(proto_start)) <= 8'h07;
	endproperty
	a_status_pos: assert property (p_status_pos) else $error("status offset range");
	property p_reset_quiet; $rose(rstn) |-> !stamp_all && !res_valid; endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("busy after reset");
	property p_stamp_window; $changed(stamp_all) |-> $past(win, 2); endproperty
	a_stamp_window: assert property (p_stamp_window) else $error("enable moved in frame");
endmodule : flow_link_checker
`default_nettype wire

// *** tb/ptp_flow_action_reconfig_bench.sv ***
/*
 * self-checking bench: both ends joined by the link, random flow setups.
 * assumes package, link interface and both ends are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module ptp_flow_action_reconfig_bench;
	import flow_action_pkg::*;
	logic                                     mclk, rstn, eng_en, strict, eth_cmp, pat_cmp;
	logic [STAGE_COUNT-1:0][FLOW_COUNT-1:0]   fv;
	logic [FLOW_COUNT-1:0][POS_W-1:0]         pos;
	logic [FLOW_COUNT-1:0]                    upd, flow_active;
	logic [FLOW_COUNT-1:0][BYTES_W-1:0]       nbytes;
	logic [FLOW_COUNT-1:0][PTR_W-1:0]         rpos, cfl;
	logic [FLOW_COUNT-1:0][CHANNEL_COUNT-1:0] chs;
	logic [FLOW_COUNT-1:0][GROUP_W-1:0]       gate;
	logic [FLOW_COUNT-1:0][PATTERN_W-1:0]     pat;
	logic [PATTERN_W-1:0]                     mask;
	logic [POS_W-1:0]                         fo;
	logic [SIGSRC_W-1:0]                      sig, ss, asg;
	logic [HEADER_W-1:0]                      hdr;
	logic [GROUP_W-1:0]                       grp, go;
	logic [PTR_W-1:0]                         ps, split, so, rp, cl, scs;
	logic [BYTES_W-1:0]                       rb;
	logic [FLOW_COUNT-1:0][BYTES_W-1:0]       anb;
	logic [2:0]                               af;
	logic                                     csel, engine_active, sop, eop, ch, hv, eth;
	logic                                     av, am, su, cs, stamp, ac;
	logic [37:0]                              expq[$];
	int                                       miscompares, tests_run;
	flow_link_if flow_link_if_inst ();
	ptp_flow_action_reconfig ptp_flow_action_reconfig_inst (.mclk(mclk), .rstn(rstn),
		.lnk(flow_link_if_inst), .engine_enable(eng_en), .strict_flow_match(strict),
		.first_ethernet_comparator(eth_cmp), .pattern_comparator_enable(pat_cmp),
		.flow_valid(fv), .status_bit_byte_position(pos), .status_bit_update_enable(upd),
		.rewrite_byte_count(nbytes), .rewrite_position(rpos), .correction_write_location(cfl),
		.flow_channel_select(chs), .next_protocol_group_gate(gate), .flow_pattern(pat),
		.flow_pattern_mask(mask), .field_offset(fo), .checksum_source_select(csel),
		.signature_address_source(sig), .engine_active(engine_active),
		.flow_active(flow_active));
	frame_datapath_end frame_datapath_end_inst (.mclk(mclk), .rstn(rstn),
		.lnk(flow_link_if_inst), .frame_sop(sop), .frame_eop(eop), .frame_channel(ch),
		.header_valid(hv), .header_word(hdr), .eth_header_found(eth), .prior_group(grp),
		.protocol_start(ps), .split_start_req(split), .action_valid(av), .action_match(am),
		.action_flow(af), .status_offset(so), .status_update(su), .rewrite_bytes(rb),
		.rewrite_pos(rp), .cf_loc(cl), .group_out(go), .chksum_sel(cs), .sig_src(ss),
		.stamp_all(stamp), .second_comparator_start(scs));
	flow_link_checker flow_link_checker_inst (.mclk(mclk), .rstn(rstn),
		.sop(flow_link_if_inst.sop), .eop(flow_link_if_inst.eop),
		.hdr_valid(flow_link_if_inst.hdr_valid), .eth_found(flow_link_if_inst.eth_found),
		.group_in(flow_link_if_inst.group_in), .proto_start(flow_link_if_inst.proto_start),
		.res_valid(flow_link_if_inst.res_valid), .res_match(flow_link_if_inst.res_match),
		.status_offset(flow_link_if_inst.status_offset),
		.status_update(flow_link_if_inst.status_update),
		.rewrite_bytes(flow_link_if_inst.rewrite_bytes),
		.rewrite_pos(flow_link_if_inst.rewrite_pos), .cf_loc(flow_link_if_inst.cf_loc),
		.group_out(flow_link_if_inst.group_out), .stamp_all(flow_link_if_inst.stamp_all));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic compare(input string what, input logic [63:0] exp, input logic [63:0] got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : compare
	task automatic test_done();
		$display("comparisons %0d, miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick
	// expected answer from the bench's own copy of the settings
	function automatic logic [37:0] model(input logic e, input logic c,
		input logic [HEADER_W-1:0] h, input logic ef, input logic [GROUP_W-1:0] g,
		input logic [PTR_W-1:0] p);
		logic [HEADER_W-1:0] sh;
		logic [37:0]         r;
		logic                act;
		sh = h << (8 * fo);
		r = {35'h0, ac, asg};
		for (int f = FLOW_COUNT - 1; f >= 0; f--) begin
			act = strict ? (fv[0][f] & fv[1][f]) : (fv[0][f] | fv[1][f]);
			if (e && act && chs[f][c] && (gate[f] & g) != '0 && (ef || !eth_cmp) &&
				(!pat_cmp || ((sh[HEADER_W-1:PATTERN_W] ^ pat[f]) & mask) == '0))
				r = {1'b1, 3'(f), 8'(p + 8'(pos[f])), upd[f], anb[f], rpos[f], cfl[f],
					gate[f] & g, ac, asg};
		end
		return r;
	endfunction : model
	task automatic frame(input logic e, input logic [HEADER_W-1:0] h);
		logic             c, ef;
		logic [GROUP_W-1:0] g;
		logic [PTR_W-1:0] p, sp, m;
		c = 1'($urandom);
		ef = ($urandom % 4) != 0;
		g = 2'($urandom);
		p = 8'($urandom);
		sp = 8'($urandom);
		m = 8'(p + 8'h08);
		@(posedge mclk) begin sop <= 1'b1; ch <= c; end
		@(posedge mclk) begin
			sop <= 1'b0; hv <= 1'b1; hdr <= h; eth <= ef; grp <= g; ps <= p; split <= sp;
		end
		expq.push_back(model(e, c, h, ef, g, p));
		@(posedge mclk) hv <= 1'b0;
		#1 compare("second start", (sp > m) ? sp : m, scs);
		@(posedge mclk) eop <= 1'b1;
		@(posedge mclk) eop <= 1'b0;
		tick(2);
	endtask : frame
	always @(posedge mclk) begin
		if (rstn && av === 1'b1) begin
			if (expq.size() == 0)
				compare("spare answer", 64'h0, 64'h1);
			else
				compare("action", expq.pop_front(), {am, af, so, su, rb, rp, cl, go, cs, ss});
		end
	end
	initial begin
		repeat (20000) @(posedge mclk);
		miscompares++;
		test_done();
	end
	initial begin
		int f;
		{rstn, eng_en, strict, eth_cmp, pat_cmp, fv, pos, upd, nbytes, rpos, cfl} = '0;
		{chs, gate, pat, mask, fo, csel, sig, sop, eop, ch, hv, hdr, eth, grp, ps, split} = '0;
		void'($urandom(40));
		tick(12);
		rstn <= 1'b1;
		tick(1);
		#1 compare("engine_active", 0, engine_active);
		compare("flow_active", 0, flow_active);
		compare("stamp_all", 0, stamp);
		$display("reset test done");
		for (int r = 0; r < 8; r++) begin
			@(posedge mclk) eng_en <= 1'b0;
			tick(3);
			@(posedge mclk) begin
				for (int k = 0; k < FLOW_COUNT; k++) begin
					pos[k] <= 3'($urandom); upd[k] <= 1'($urandom); nbytes[k] <= 4'($urandom);
					rpos[k] <= 8'($urandom); cfl[k] <= 8'($urandom); chs[k] <= 2'($urandom);
					gate[k] <= 2'($urandom); pat[k] <= {$urandom, $urandom};
				end
				fv <= 16'($urandom | $urandom); strict <= r[0]; eth_cmp <= (r != 5);
				pat_cmp <= (r != 3); csel <= r[2]; sig <= 2'(r); fo <= 3'($urandom);
				mask <= {$urandom, $urandom};
			end
			// settings the engine should keep while it runs
			@(posedge mclk) begin ac <= csel; asg <= sig; anb <= nbytes; end
			tick(1);
			@(posedge mclk) eng_en <= 1'b1;
			tick(3);
			#1 compare("engine_active", 1, engine_active);
			compare("stamp_all", !eth_cmp, stamp);
			compare("flow_active", strict ? (fv[0] & fv[1]) : (fv[0] | fv[1]), flow_active);
			// writes while engine and flows run must be ignored
			@(posedge mclk) begin csel <= ~csel; sig <= ~sig; nbytes <= ~nbytes; end
			repeat (12) begin
				f = $urandom % FLOW_COUNT;
				frame(1'b1, ($urandom % 4 == 0) ? {$urandom, $urandom, $urandom, $urandom} :
					({pat[f], $urandom, $urandom} >> (8 * fo)));
			end
			$display("round %0d done", r);
		end
		@(posedge mclk) sop <= 1'b1;
		@(posedge mclk) begin sop <= 1'b0; eng_en <= 1'b0; end
		tick(3);
		#1 compare("engine_active", 1, engine_active);
		@(posedge mclk) eop <= 1'b1;
		@(posedge mclk) eop <= 1'b0;
		tick(2);
		#1 compare("engine_active", 0, engine_active);
		// common settings follow software again once the engine is off
		ac = csel;
		asg = sig;
		frame(1'b0, {$urandom, $urandom, $urandom, $urandom});
		tick(4);
		compare("pending answers", 0, expq.size());
		$display("mid-frame test done");
		test_done();
	end
endmodule : ptp_flow_action_reconfig_bench
`default_nettype wire
